// [core/sasp_cfg.svh]
`ifndef SASP_CFG_SVH
`define SASP_CFG_SVH

// register byte offsets on the plain register port
`define SASP_ADDR_W        8
`define SASP_REG_CTRL      8'h00
`define SASP_REG_MODE      8'h04
`define SASP_REG_PSC       8'h08
`define SASP_REG_FCTRL     8'h0C
`define SASP_REG_TXDATA    8'h10
`define SASP_REG_RXDATA    8'h14

// control register fields
`define SASP_CTRL_EN       0
`define SASP_CTRL_PSC_EN   1
`define SASP_CTRL_RX_IDLE  2
`define SASP_CTRL_TX_IDLE  3
`define SASP_CTRL_RX_DMA   4
`define SASP_CTRL_TX_DMA   5
`define SASP_CTRL_RX_RDY   6
`define SASP_CTRL_TX_RDY   7
`define SASP_CTRL_LR_IDX   8

// mode register fields
`define SASP_MODE_BCLK     0
`define SASP_MODE_MCLK     2
`define SASP_MODE_W16      3
`define SASP_MODE_MSBJ     4
`define SASP_MODE_POL      5
`define SASP_MODE_XFER     6
`define SASP_MODE_SLAVE    8

// prescaler register fields, five bits each
`define SASP_PSC_W         5
`define SASP_PSC_B         0
`define SASP_PSC_A         5

// queue control register fields
`define SASP_FC_RXCNT      0
`define SASP_FC_TXCNT      4
`define SASP_FC_RX_EN      8
`define SASP_FC_TX_EN      9
`define SASP_FC_RX_DMAM    10
`define SASP_FC_TX_DMAM    11

// queues: eight halfwords, sixteen bytes each way
`define SASP_FIFO_DEPTH    4'h8
`define SASP_DEPTH_N       8
`define SASP_PTR_W         3
`define SASP_QCNT_W        4

// clock ratios to the sampling rate
`define SASP_MCLK_256      256
`define SASP_MCLK_384      384
`define SASP_BCLK_16       16
`define SASP_BCLK_32       32
`define SASP_BCLK_48       48

// sample widths in bits
`define SASP_W8            5'h08
`define SASP_W16           5'h10

`endif

// [core/sasp_pkg.sv]
`include "sasp_cfg.svh"

package sasp_pkg;

	// transfer direction, order matches the mode field encoding
	typedef enum logic [1:0] {
		SASP_XFER_NONE,
		SASP_XFER_RX,
		SASP_XFER_TX,
		SASP_XFER_BOTH
	} sasp_xfer_t;

	typedef struct packed {
		logic [`SASP_ADDR_W-1:0] addr;
		logic [31:0]             wdata;
		logic                    wr;
		logic                    rd;
	} sasp_bus_req_t;

	typedef struct packed {
		logic serial_bit_clock;
		logic channel_select_line;
		logic serial_data_in;
	} sasp_link_in_t;

	typedef struct packed {
		logic serial_bit_clock;
		logic serial_bit_clock_oe;
		logic channel_select_line;
		logic channel_select_line_oe;
		logic serial_data_out;
	} sasp_link_out_t;

	typedef struct packed {
		logic                                   en;
		logic                                   psc_en;
		logic                                   rx_idle;
		logic                                   tx_idle;
		logic                                   rx_dma;
		logic                                   tx_dma;
		logic                                   slave;
		sasp_xfer_t                             xfer;
		logic                                   pol;
		logic                                   msbj;
		logic                                   w16;
		logic                                   mclk384;
		logic [1:0]                             bclk;
		logic [`SASP_PSC_W-1:0]                 psc_a;
		logic [`SASP_PSC_W-1:0]                 psc_b;
		logic [`SASP_PSC_W-1:0]                 cnt_a;
		logic [`SASP_PSC_W-1:0]                 cnt_b;
		logic                                   tx_dmam;
		logic                                   rx_dmam;
		logic                                   tx_fen;
		logic                                   rx_fen;
		logic                                   codec_clk;
		logic [3:0]                             half_cnt;
		logic                                   sclk;
		logic                                   lrck_n;
		logic [4:0]                             bit_cnt;
		logic [2:0]                             sclk_sy;
		logic [2:0]                             lr_sy;
		logic [2:0]                             di_sy;
		logic                                   sclk_f;
		logic                                   lr_f;
		logic                                   di_f;
		logic                                   sclk_d;
		logic                                   lr_d;
		logic                                   pending;
		logic [15:0]                            tx_sh;
		logic                                   sdo;
		logic [15:0]                            rx_sh;
		logic [4:0]                             rx_bits;
		logic [`SASP_DEPTH_N-1:0][15:0]         tx_mem;
		logic [`SASP_DEPTH_N-1:0][15:0]         rx_mem;
		logic [`SASP_PTR_W-1:0]                 tx_wp;
		logic [`SASP_PTR_W-1:0]                 tx_rp;
		logic [`SASP_PTR_W-1:0]                 rx_wp;
		logic [`SASP_PTR_W-1:0]                 rx_rp;
		logic [`SASP_QCNT_W-1:0]                txq_cnt;
		logic [`SASP_QCNT_W-1:0]                rxq_cnt;
		logic [31:0]                            rdata;
	} sasp_state_t;

endpackage

// [core/sasp_core.sv]
// How it works
// - standard or MSB-justified framing, chosen by a mode bit
// - both channels use one word width, eight or sixteen bits
// - bit clock is 16, 32 or 48 times the sample rate
// - codec master clock ratio is 256 or 384 times the sample rate
// - separate sixteen-byte transmit and receive queues
// - two independent five-bit prescalers, internal and codec clock
// - master mode divides internal clock into bit clock, drives both lines
// - sixteen-bit shift registers serialise and assemble sample words
// - transmit ready flag is one while the transmit queue holds data
// - receive ready flag is one while the receive queue has room
// - DMA requests follow queue state in DMA access mode
// - transmit only, receive only, or both at once
// - four lines; whoever drives bit clock and channel select is master
// - samples go out two's complement, most significant bit first
// - trailing bit positions beyond the sample are sent as zeros
// - excess received bits dropped, missing low bits become zero
// - standard format: MSB one bit period after channel select changes
// - data captured on rising bit clock, launched on falling edge
// - slave acts on a channel select change as soon as the filtered pin moves
// - justified format: MSB in the same period as the select change
// - each prescaler divides its input by the value plus one
// - channel select polarity for the left channel is configurable
// - an idle command holds channel select still in master mode and pauses transfer
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "sasp_cfg.svh"

module sasp_core
	import sasp_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire sasp_bus_req_t  bus_req,
	output logic [31:0]         bus_rdata,
	input  wire sasp_link_in_t  link_in,
	output sasp_link_out_t      link_out,
	output logic                codec_master_clock,
	output logic                tx_dma_req,
	output logic                rx_dma_req
);

	sasp_state_t        s;
	sasp_state_t        n;
	logic               master;
	logic               tx_on;
	logic               rx_on;
	logic               freeze;
	logic               tick_a;
	logic               tick_b;
	logic [3:0]         half;
	logic [4:0]         bpc;
	logic [4:0]         width;
	logic               m_edge;
	logic               rise;
	logic               fall;
	logic               lr_change;
	logic               load;
	logic               tx_take;
	logic               rx_put;
	logic               tx_push;
	logic               rx_pop;
	logic               tx_ready;
	logic               rx_ready;
	logic               lr_line;
	logic [15:0]        tx_word;
	logic [31:0]        rd_val;

	// master ticks per half bit clock for each clock ratio pair
	function automatic logic [3:0] half_of(input logic m384, input logic [1:0] b);
		logic [3:0] h;
		h = 4'((`SASP_MCLK_256) / (2 * `SASP_BCLK_32));
		unique case ({m384, b})
			3'h0: h = 4'((`SASP_MCLK_256) / (2 * `SASP_BCLK_16));
			3'h1: h = 4'((`SASP_MCLK_256) / (2 * `SASP_BCLK_32));
			3'h2: h = 4'((`SASP_MCLK_256) / (2 * `SASP_BCLK_48));
			3'h4: h = 4'((`SASP_MCLK_384) / (2 * `SASP_BCLK_16));
			3'h5: h = 4'((`SASP_MCLK_384) / (2 * `SASP_BCLK_32));
			3'h6: h = 4'((`SASP_MCLK_384) / (2 * `SASP_BCLK_48));
			default: h = 4'((`SASP_MCLK_256) / (2 * `SASP_BCLK_32));
		endcase
		return h;
	endfunction

	// bit periods per channel: half the frame ratio
	function automatic logic [4:0] bpc_of(input logic [1:0] b);
		logic [4:0] v;
		v = 5'(`SASP_BCLK_32 / 2);
		unique case (b)
			2'h0: v = 5'(`SASP_BCLK_16 / 2);
			2'h1: v = 5'(`SASP_BCLK_32 / 2);
			2'h2: v = 5'(`SASP_BCLK_48 / 2);
			default: v = 5'(`SASP_BCLK_32 / 2);
		endcase
		return v;
	endfunction

	// mode decode
	assign master = ~s.slave;
	assign tx_on  = (s.xfer == SASP_XFER_TX) || (s.xfer == SASP_XFER_BOTH);
	assign rx_on  = (s.xfer == SASP_XFER_RX) || (s.xfer == SASP_XFER_BOTH);
	assign freeze = s.tx_idle | s.rx_idle;
	assign half   = half_of(s.mclk384, s.bclk);
	assign bpc    = bpc_of(s.bclk);
	assign width  = s.w16 ? `SASP_W16 : `SASP_W8;

	assign tick_a = s.psc_en & (s.cnt_a == s.psc_a);
	assign tick_b = s.psc_en & (s.cnt_b == s.psc_b);

	// bit clock edges from the internal master tick in master mode
	assign m_edge = s.en & master & tick_a & (s.half_cnt == (half - 4'h1));
	// slave edges come from the filtered pins
	assign rise   = master ? (m_edge & ~s.sclk) : (s.en & s.sclk_f & ~s.sclk_d);
	assign fall   = master ? (m_edge & s.sclk) : (s.en & ~s.sclk_f & s.sclk_d);

	// an idle command stops master channel select from moving and makes a slave ignore select changes
	assign lr_change = master ? (fall & ~freeze & (s.bit_cnt == (bpc - 5'h01)))
	                          : (s.en & ~freeze & (s.lr_f != s.lr_d));
	// justified loads at the change, standard one bit later
	assign load = (lr_change & s.msbj) | (fall & s.pending);

	assign tx_take = load & tx_on & ~s.tx_idle & s.tx_fen & (s.txq_cnt != '0);
	assign rx_put  = load & rx_on & ~s.rx_idle & s.rx_fen & (s.rx_bits != '0)
	               & (s.rxq_cnt != `SASP_FIFO_DEPTH);
	assign tx_push = bus_req.wr & (bus_req.addr == `SASP_REG_TXDATA) & s.tx_fen
	               & (s.txq_cnt != `SASP_FIFO_DEPTH);
	assign rx_pop  = bus_req.rd & (bus_req.addr == `SASP_REG_RXDATA) & (s.rxq_cnt != '0);

	assign tx_ready = (s.txq_cnt != '0);
	assign rx_ready = (s.rxq_cnt != `SASP_FIFO_DEPTH);

	// eight-bit samples sit at the top, low bits zero
	assign tx_word = ~tx_take ? 16'h0000
	               : s.w16 ? s.tx_mem[s.tx_rp] : {s.tx_mem[s.tx_rp][7:0], 8'h00};

	// index is the line level relative to the left polarity
	assign lr_line = master ? ~s.lrck_n : s.lr_f;

	// register read mux, unmapped offsets read zero
	always_comb begin
		rd_val = '0;
		unique case (bus_req.addr)
			`SASP_REG_CTRL: begin
				rd_val[`SASP_CTRL_EN]      = s.en;
				rd_val[`SASP_CTRL_PSC_EN]  = s.psc_en;
				rd_val[`SASP_CTRL_RX_IDLE] = s.rx_idle;
				rd_val[`SASP_CTRL_TX_IDLE] = s.tx_idle;
				rd_val[`SASP_CTRL_RX_DMA]  = s.rx_dma;
				rd_val[`SASP_CTRL_TX_DMA]  = s.tx_dma;
				rd_val[`SASP_CTRL_RX_RDY]  = rx_ready;
				rd_val[`SASP_CTRL_TX_RDY]  = tx_ready;
				rd_val[`SASP_CTRL_LR_IDX]  = lr_line ^ s.pol;
			end
			`SASP_REG_MODE: begin
				rd_val[`SASP_MODE_BCLK +: 2] = s.bclk;
				rd_val[`SASP_MODE_MCLK]      = s.mclk384;
				rd_val[`SASP_MODE_W16]       = s.w16;
				rd_val[`SASP_MODE_MSBJ]      = s.msbj;
				rd_val[`SASP_MODE_POL]       = s.pol;
				rd_val[`SASP_MODE_XFER +: 2] = s.xfer;
				rd_val[`SASP_MODE_SLAVE]     = s.slave;
			end
			`SASP_REG_PSC: begin
				rd_val[`SASP_PSC_A +: `SASP_PSC_W] = s.psc_a;
				rd_val[`SASP_PSC_B +: `SASP_PSC_W] = s.psc_b;
			end
			`SASP_REG_FCTRL: begin
				rd_val[`SASP_FC_RXCNT +: `SASP_QCNT_W] = s.rxq_cnt;
				rd_val[`SASP_FC_TXCNT +: `SASP_QCNT_W] = s.txq_cnt;
				rd_val[`SASP_FC_RX_EN]   = s.rx_fen;
				rd_val[`SASP_FC_TX_EN]   = s.tx_fen;
				rd_val[`SASP_FC_RX_DMAM] = s.rx_dmam;
				rd_val[`SASP_FC_TX_DMAM] = s.tx_dmam;
			end
			`SASP_REG_RXDATA: rd_val[15:0] = s.rx_mem[s.rx_rp];
			default: rd_val = '0;
		endcase
	end

	// next state of the whole block
	always_comb begin
		n = s;
		// read data stand for the one cycle after the strobe only
		n.rdata = bus_req.rd ? rd_val : '0;

		// register writes
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				`SASP_REG_CTRL: begin
					n.en      = bus_req.wdata[`SASP_CTRL_EN];
					n.psc_en  = bus_req.wdata[`SASP_CTRL_PSC_EN];
					n.rx_idle = bus_req.wdata[`SASP_CTRL_RX_IDLE];
					n.tx_idle = bus_req.wdata[`SASP_CTRL_TX_IDLE];
					n.rx_dma  = bus_req.wdata[`SASP_CTRL_RX_DMA];
					n.tx_dma  = bus_req.wdata[`SASP_CTRL_TX_DMA];
				end
				`SASP_REG_MODE: begin
					n.bclk    = bus_req.wdata[`SASP_MODE_BCLK +: 2];
					n.mclk384 = bus_req.wdata[`SASP_MODE_MCLK];
					n.w16     = bus_req.wdata[`SASP_MODE_W16];
					n.msbj    = bus_req.wdata[`SASP_MODE_MSBJ];
					n.pol     = bus_req.wdata[`SASP_MODE_POL];
					n.xfer    = sasp_xfer_t'(bus_req.wdata[`SASP_MODE_XFER +: 2]);
					n.slave   = bus_req.wdata[`SASP_MODE_SLAVE];
				end
				`SASP_REG_PSC: begin
					n.psc_a = bus_req.wdata[`SASP_PSC_A +: `SASP_PSC_W];
					n.psc_b = bus_req.wdata[`SASP_PSC_B +: `SASP_PSC_W];
				end
				`SASP_REG_FCTRL: begin
					n.rx_fen  = bus_req.wdata[`SASP_FC_RX_EN];
					n.tx_fen  = bus_req.wdata[`SASP_FC_TX_EN];
					n.rx_dmam = bus_req.wdata[`SASP_FC_RX_DMAM];
					n.tx_dmam = bus_req.wdata[`SASP_FC_TX_DMAM];
				end
				default: n.rdata = n.rdata;
			endcase
		end

		if (s.psc_en) begin
			n.cnt_a = tick_a ? '0 : s.cnt_a + 5'h01;
			n.cnt_b = tick_b ? '0 : s.cnt_b + 5'h01;
		end
		// codec clock toggles per prescaler B tick
		if (tick_b)
			n.codec_clk = ~s.codec_clk;

		// pin synchronisers: first stage feeds only the second
		n.sclk_sy = {s.sclk_sy[1:0], link_in.serial_bit_clock};
		n.lr_sy   = {s.lr_sy[1:0], link_in.channel_select_line};
		n.di_sy   = {s.di_sy[1:0], link_in.serial_data_in};
		// a change counts once second and third stages agree
		if (s.sclk_sy[1] == s.sclk_sy[2])
			n.sclk_f = s.sclk_sy[2];
		if (s.lr_sy[1] == s.lr_sy[2])
			n.lr_f = s.lr_sy[2];
		if (s.di_sy[1] == s.di_sy[2])
			n.di_f = s.di_sy[2];
		n.sclk_d = s.sclk_f;
		n.lr_d   = s.lr_f;

		if (s.en & master & tick_a) begin
			if (s.half_cnt == (half - 4'h1)) begin
				n.half_cnt = '0;
				n.sclk     = ~s.sclk;
			end else begin
				n.half_cnt = s.half_cnt + 4'h1;
			end
		end

		// master channel select toggles on a falling edge
		if (master & fall & ~freeze) begin
			n.bit_cnt = lr_change ? '0 : s.bit_cnt + 5'h01;
			if (lr_change)
				n.lrck_n = ~s.lrck_n;
		end

		// standard format waits one falling edge
		if (lr_change & ~s.msbj)
			n.pending = 1'b1;
		else if (fall)
			n.pending = 1'b0;

		// transmit shifter, MSB first, zeros shifted in
		if (load) begin
			n.sdo   = tx_word[15];
			n.tx_sh = {tx_word[14:0], 1'b0};
		end else if (fall) begin
			n.sdo   = s.tx_sh[15];
			n.tx_sh = {s.tx_sh[14:0], 1'b0};
		end

		// receive shifter; word boundary pushes and clears
		if (load) begin
			n.rx_sh   = '0;
			n.rx_bits = '0;
		// capture on the rising edge, extra bits dropped
		end else if (rise && (s.rx_bits < width)) begin
			n.rx_sh[4'hF - s.rx_bits[3:0]] = s.di_f;
			n.rx_bits = s.rx_bits + 5'h01;
		end

		if (tx_push) begin
			n.tx_mem[s.tx_wp] = bus_req.wdata[15:0];
			n.tx_wp           = s.tx_wp + 3'h1;
		end
		if (tx_take)
			n.tx_rp = s.tx_rp + 3'h1;
		n.txq_cnt = s.txq_cnt + {3'h0, tx_push} - {3'h0, tx_take};

		// receive queue; short words sit in the low byte, high bits zero
		if (rx_put) begin
			n.rx_mem[s.rx_wp] = s.w16 ? s.rx_sh : {8'h00, s.rx_sh[15:8]};
			n.rx_wp           = s.rx_wp + 3'h1;
		end
		if (rx_pop)
			n.rx_rp = s.rx_rp + 3'h1;
		n.rxq_cnt = s.rxq_cnt + {3'h0, rx_put} - {3'h0, rx_pop};

		// a disabled queue is flushed so it restarts clean
		if (~s.tx_fen) begin
			n.tx_wp   = '0;
			n.tx_rp   = '0;
			n.txq_cnt = '0;
		end
		if (~s.rx_fen) begin
			n.rx_wp   = '0;
			n.rx_rp   = '0;
			n.rxq_cnt = '0;
		end

		// stopping the port parks the engine so a restart is framed cleanly
		if (~s.en) begin
			n.half_cnt = '0;
			n.sclk     = 1'b0;
			n.bit_cnt  = '0;
			n.pending  = 1'b0;
			n.tx_sh    = '0;
			n.sdo      = 1'b0;
			n.rx_sh    = '0;
			n.rx_bits  = '0;
		end
	end

	// reset empties queues and clears shifters
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	// requests only while enabled and in DMA access mode
	// transmit asks while the queue has room, receive while data waits
	assign tx_dma_req = s.en & s.tx_dma & s.tx_dmam & s.tx_fen
	                  & (s.txq_cnt != `SASP_FIFO_DEPTH);
	assign rx_dma_req = s.en & s.rx_dma & s.rx_dmam & s.rx_fen & (s.rxq_cnt != '0);

	// master drives clock and select, slave leaves them as inputs
	assign link_out.serial_bit_clock       = s.sclk;
	assign link_out.serial_bit_clock_oe    = master;
	assign link_out.channel_select_line    = ~s.lrck_n;
	assign link_out.channel_select_line_oe = master;
	assign link_out.serial_data_out        = s.sdo;
	assign codec_master_clock              = s.codec_clk;
	assign bus_rdata                       = s.rdata;

endmodule

`default_nettype wire

// [dv/sasp_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sasp_cfg.svh"
module sasp_props
	import sasp_pkg::*;
(
	input wire logic           clk,
	input wire logic           rst,
	input wire sasp_bus_req_t  bus_req,
	input wire logic [31:0]    bus_rdata,
	input wire sasp_link_in_t  link_in,
	input wire sasp_link_out_t link_out,
	input wire logic           codec_master_clock,
	input wire logic           tx_dma_req,
	input wire logic           rx_dma_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_rdata_idle;
		!$past(bus_req.rd) |-> bus_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data off slot");
	property p_reset_state;
		$fell(rst) |-> !tx_dma_req && !rx_dma_req && link_out.channel_select_line;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad reset state");
	property p_oe_pair;
		link_out.serial_bit_clock_oe == link_out.channel_select_line_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
	property p_sel_edge;
		link_out.channel_select_line_oe && $changed(link_out.channel_select_line)
			|-> $fell(link_out.serial_bit_clock);
	endproperty
	a_sel_edge: assert property (p_sel_edge) else $error("select off edge");
	property p_sdo_edge;
		$changed(link_out.serial_data_out) |-> !link_out.serial_bit_clock;
	endproperty
	a_sdo_edge: assert property (p_sdo_edge) else $error("data moved at high");
	property p_sclk_hold;
		$rose(link_out.serial_bit_clock) && link_out.serial_bit_clock_oe
			|=> link_out.serial_bit_clock [*2];
	endproperty
	a_sclk_hold: assert property (p_sclk_hold) else $error("short clock phase");
	property p_tx_dma_off;
		bus_req.wr && bus_req.addr == `SASP_REG_CTRL && !bus_req.wdata[`SASP_CTRL_TX_DMA]
			|=> !tx_dma_req;
	endproperty
	a_tx_dma_off: assert property (p_tx_dma_off) else $error("tx request stays");
	property p_rx_dma_off;
		bus_req.wr && bus_req.addr == `SASP_REG_FCTRL && !bus_req.wdata[`SASP_FC_RX_DMAM]
			|=> !rx_dma_req;
	endproperty
	a_rx_dma_off: assert property (p_rx_dma_off) else $error("rx request stays");
endmodule
bind sasp_core sasp_props u_props (
	.clk(clk),
	.rst(rst),
	.bus_req(bus_req),
	.bus_rdata(bus_rdata),
	.link_in(link_in),
	.link_out(link_out),
	.codec_master_clock(codec_master_clock),
	.tx_dma_req(tx_dma_req),
	.rx_dma_req(rx_dma_req)
);
`default_nettype wire

// [dv/sasp_codec.sv]
`timescale 1ns/10ps
`default_nettype none
module sasp_codec (
	input  wire logic        rst,
	input  wire logic        sclk,
	input  wire logic        sel,
	input  wire logic        sdo,
	input  wire logic        msbj,
	input  wire logic [15:0] sample,
	output var logic         sdi,
	output var logic [15:0]  word,
	output var int           cnt
);
	logic [15:0] acc;
	int          ri;
	int          ti;
	logic        rsel;
	logic        tsel;
	// capture on rise, word restarts at select change
	always @(posedge sclk or posedge rst) begin
		if (rst) begin
			acc = 16'h0;
			ri = 99;
			rsel = sel;
			word = 16'h0;
			cnt = 0;
		end else begin
			// justified: the select change opens the new word at once
			if (sel != rsel && msbj) begin
				word = acc;
				cnt = cnt + 1;
				acc = 16'h0;
				ri = 0;
			end
			if (ri >= 0 && ri < 16)
				acc[15 - ri] = sdo;
			ri = ri + 1;
			// standard: the changed period still carries the old word's last bit
			if (sel != rsel && !msbj) begin
				word = acc;
				cnt = cnt + 1;
				acc = 16'h0;
				ri = 0;
			end
			rsel = sel;
		end
	end
	// launch on fall, zeros once the word is out
	always @(negedge sclk or posedge rst) begin
		if (rst) begin
			sdi <= 1'b0;
			ti = 99;
			tsel = sel;
		end else begin
			if (sel != tsel && msbj)
				ti = 0;
			sdi <= (ti >= 0 && ti < 16) ? sample[15 - ti] : 1'b0;
			ti = ti + 1;
			// standard: finish the old word in the changed period, MSB next
			if (sel != tsel && !msbj)
				ti = 0;
			tsel = sel;
		end
	end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sasp_cfg.svh"
module tb_top;
	import sasp_pkg::*;
	logic           clk;
	logic           rst;
	sasp_bus_req_t  bus_req;
	logic [31:0]    bus_rdata;
	sasp_link_in_t  link_in;
	sasp_link_out_t link_out;
	logic           codec_master_clock;
	logic           tx_dma_req;
	logic           rx_dma_req;
	logic           msbj;
	logic [15:0]    sample;
	logic           sdi;
	logic [15:0]    word;
	int             cnt;
	logic           rd_q;
	logic [31:0]    q_rd[$];
	logic [31:0]    q_mk[$];
	logic [15:0]    q_ser[$];
	int             error_cnt;
	int             checks_done;
	int             ser_seen;
	logic [8:0]     mt[4] = '{9'h0C9, 9'h0F0, 9'h0DE, 9'h0E5};
	int             ht[4] = '{4, 8, 4, 6};

	sasp_core dut (
		.clk(clk),
		.rst(rst),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.link_in(link_in),
		.link_out(link_out),
		.codec_master_clock(codec_master_clock),
		.tx_dma_req(tx_dma_req),
		.rx_dma_req(rx_dma_req)
	);
	sasp_codec codec (
		.rst(rst),
		.sclk(link_in.serial_bit_clock),
		.sel(link_in.channel_select_line),
		.sdo(link_out.serial_data_out),
		.msbj(msbj),
		.sample(sample),
		.sdi(sdi),
		.word(word),
		.cnt(cnt)
	);
	// undriven clock and select pins are pulled low
	assign link_in = '{link_out.serial_bit_clock_oe & link_out.serial_bit_clock,
		link_out.channel_select_line_oe & link_out.channel_select_line, sdi};

	task automatic conclude();
		$display("errors=%0d checks=%0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// strobe one cycle, then one idle cycle so no signal is set twice at an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= '{a, d, 1'b0, 1'b0};
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		q_rd.push_back(e & m);
		q_mk.push_back(m);
		bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '{a, 32'h0, 1'b0, 1'b0};
		@(posedge clk);
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	// clk cycles between two rising edges, sampled mid-cycle
	task automatic period(input bit b, input int exp);
		logic p;
		logic v;
		int   e[2];
		int   k;
		k = 0;
		p = 1'b1;
		e = '{0, 0};
		for (int i = 0; i < 4000 && k < 2; i++) begin
			@(negedge clk);
			v = b ? link_out.serial_bit_clock : codec_master_clock;
			if (v && !p) begin
				e[k] = i;
				k++;
			end
			p = v;
		end
		cmp(e[1] - e[0], exp);
		@(posedge clk);
	endtask
	task automatic wait_ser(input int n);
		for (int i = 0; i < 30000 && ser_seen < n; i++)
			@(posedge clk);
		if (ser_seen < n) begin
			error_cnt++;
			conclude();
		end
	endtask

	// read results stand in the cycle after the strobe
	always @(posedge clk) rd_q <= bus_req.rd;
	always @(negedge clk) begin
		if (rd_q)
			cmp(bus_rdata & q_mk.pop_front(), q_rd.pop_front());
	end
	// empty queue sends zeros, so only nonzero words are results
	always @(cnt) begin
		if (cnt > 0 && word !== 16'h0) begin
			ser_seen++;
			cmp(word, q_ser.size() ? q_ser.pop_front() : 16'hFFFF);
		end
	end

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		int          a;
		int          b;
		int          wt;
		logic [31:0] s;
		logic        w16;
		logic        sel;
		rst = 1'b1;
		bus_req = '0;
		msbj = 1'b0;
		sample = 16'h0;
		error_cnt = 0;
		checks_done = 0;
		ser_seen = 0;
		s = $urandom(32'h787878e1);
		@(posedge clk);
		do_reset();
		rd(`SASP_REG_MODE, 32'h0, 32'hFFFFFFFF);
		rd(`SASP_REG_FCTRL, 32'h0, 32'hFFFFFFFF);
		rd(8'h18, 32'h0, 32'hFFFFFFFF);
		rd(`SASP_REG_TXDATA, 32'h0, 32'hFFFFFFFF);
		// supported ratio pairs only; formats, widths and polarity per pass
		for (int c = 0; c < 4; c++) begin
			// A of one or two keeps each half bit period past the pin sync delay
			a = 1 + $urandom % 2;
			b = $urandom % 32;
			sample = $urandom;
			msbj = mt[c][4];
			w16 = mt[c][3];
			wt = 8 * (mt[c][1:0] + 1) * 2 * ht[c] * (a + 1);
			do_reset();
			wr(`SASP_REG_CTRL, 32'h0);
			wr(`SASP_REG_PSC, (a << `SASP_PSC_A) | b);
			wr(`SASP_REG_MODE, mt[c]);
			wr(`SASP_REG_FCTRL, 32'hA00);
			for (int i = 0; i < 9; i++) begin
				s = $urandom | 32'h1;
				wr(`SASP_REG_TXDATA, s);
				if (i < 8)
					q_ser.push_back(w16 ? s[15:0] : {s[7:0], 8'h00});
			end
			rd(`SASP_REG_FCTRL, 32'hA80, 32'hFFF);
			wr(`SASP_REG_CTRL, 32'h33);
			rd(`SASP_REG_CTRL, 32'hF3, 32'hFF);
			@(negedge clk);
			cmp(tx_dma_req, 1'b0);
			period(1'b0, 2 * (b + 1));
			period(1'b1, 2 * ht[c] * (a + 1));
			// open the receive queue after a framed load, so no part word lands
			@(negedge clk);
			sel = link_out.channel_select_line;
			for (int i = 0; i < 4000 && link_out.channel_select_line == sel; i++)
				@(negedge clk);
			if (link_out.channel_select_line == sel) begin
				error_cnt++;
				conclude();
			end
			repeat (wt / 2) @(posedge clk);
			wr(`SASP_REG_FCTRL, 32'hF00);
			wait_ser(8 * (c + 1));
			repeat (3 * wt) @(posedge clk);
			wr(`SASP_REG_CTRL, 32'h3F);
			@(negedge clk);
			cmp(tx_dma_req, 1'b1);
			cmp(rx_dma_req, 1'b1);
			@(posedge clk);
			rd(`SASP_REG_FCTRL, 32'hF08, 32'hFFF);
			rd(`SASP_REG_CTRL, 32'h3F, 32'hFF);
			sel = link_out.channel_select_line;
			rd(`SASP_REG_CTRL, {23'h0, sel ^ mt[c][5], 8'h00}, 32'h100);
			repeat (2 * wt) @(posedge clk);
			cmp(link_out.channel_select_line, sel);
			for (int i = 0; i < 8; i++)
				rd(`SASP_REG_RXDATA, w16 ? sample : {8'h00, sample[15:8]}, 32'hFFFF);
			rd(`SASP_REG_FCTRL, 32'hF00, 32'hFFF);
		end
		conclude();
	end
endmodule
`default_nettype wire
